// ==== verilog/tmf_regs.vh ====
// Register offsets, field positions and reset values of the transmit MAC bank
`ifndef TMF_REGS_VH
`define TMF_REGS_VH

// Word indices; byte address is four times the index
`define TMF_IDX_REVISION     12'h400
`define TMF_IDX_SCRATCH      12'h401
`define TMF_IDX_IDENT_FIRST  12'h402
`define TMF_IDX_IDENT_MIDDLE 12'h403
`define TMF_IDX_IDENT_LAST   12'h404
`define TMF_IDX_FAULT_CTRL   12'h405
`define TMF_IDX_IDLE_REMOVE  12'h406
`define TMF_IDX_SIZE_LIMIT   12'h407
`define TMF_IDX_FAULT_FLAGS  12'h508
`define TMF_IDX_IRQ_STATUS   12'h510
`define TMF_IDX_IRQ_MASK     12'h511
`define TMF_IDX_OVS_LOW      12'h512
`define TMF_IDX_OVS_HIGH     12'h513

`define TMF_BIT_UNIDIR       1
`define TMF_BIT_FAULT_GEN    0
`define TMF_BIT_REMOTE       1
`define TMF_BIT_LOCAL        0

`define TMF_RST_SCRATCH      32'h00000000
`define TMF_RST_FAULT_CTRL   2'h1
`define TMF_RST_FAULT_FLAGS  2'h1
`define TMF_RST_IDLE_REMOVE  8'h14
`define TMF_RST_SIZE_LIMIT   16'h2580
`define TMF_RST_IRQ_MASK     3'h0

// Arbitrary neutral values standing in for identification codes
`define TMF_REVISION_CODE    32'h00010000
`define TMF_IDENT_FIRST      32'h54455354
`define TMF_IDENT_MIDDLE     32'h4D414354
`define TMF_IDENT_LAST       32'h58524547

`define TMF_RD_MISS          32'h00000000

`endif

// ==== verilog/tmf_mac_regs.v ====
// Transmit MAC control, fault signalling and fault status register bank
`timescale 1ns/1ps
`include "tmf_regs.vh"

module tmf_mac_regs
#(
    parameter LINK_FAULT_EN = 1,
    parameter IDLE_DEFICIT  = 1,
    parameter TX_STATS      = 1
)
(
    input  wire        ref_clk,
    input  wire        resetn,
    input  wire [11:0] avs_address,
    input  wire        avs_read,
    input  wire        avs_write,
    input  wire [31:0] avs_writedata,
    input  wire [3:0]  avs_byteenable,
    output reg  [31:0] avs_readdata,
    output reg         avs_waitrequest,
    input  wire        rx_local_fault,
    input  wire        rx_remote_fault,
    input  wire        tx_frame_done,
    input  wire [15:0] tx_frame_len,
    output reg         local_fault_status,
    output reg         remote_fault_status,
    output reg         fault_gen_enable,
    output reg         unidir_enable,
    output reg  [7:0]  idle_column_removal_count,
    output reg  [15:0] tx_frame_size_limit,
    output reg         irq
);

// ==========================================================
// Input synchronisers
reg  [1:0]  loc_sync_q;
reg  [1:0]  rem_sync_q;

always @(posedge ref_clk)
begin
    if (!resetn)
    begin
        loc_sync_q <= 2'h3;
        rem_sync_q <= 2'h0;
    end
    else
    begin
        loc_sync_q <= {loc_sync_q[0], rx_local_fault};
        rem_sync_q <= {rem_sync_q[0], rx_remote_fault};
    end
end

// ==========================================================
// Register state
reg  [31:0] scratch_q;
reg  [1:0]  fault_ctrl_q;
reg  [7:0]  idle_rem_q;
reg  [15:0] size_limit_q;
reg  [1:0]  flags_q;
reg  [2:0]  irq_sts_q;
reg  [2:0]  irq_msk_q;
reg  [63:0] ovs_cnt_q;
reg         ovs_evt_q;
reg         bus_done_q;
reg  [1:0]  flags_prev_q;

wire        acc      = (avs_read || avs_write) && !bus_done_q;
// Commit on the edge where the master sees waitrequest low
wire        wr       = avs_write && !avs_waitrequest;
wire [31:0] be_mask  = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                        {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
wire [1:0]  flags_d  = {rem_sync_q[1], loc_sync_q[1]};
wire [1:0]  ctrl_wd  = (avs_writedata[1:0] & be_mask[1:0])
                     | (fault_ctrl_q & ~be_mask[1:0]);
wire [2:0]  irq_evt  = {ovs_evt_q, flags_prev_q ^ flags_q};

// ==========================================================
// Register writes
always @(posedge ref_clk)
begin
    if (!resetn)
    begin
        scratch_q    <= `TMF_RST_SCRATCH;
        fault_ctrl_q <= `TMF_RST_FAULT_CTRL;
        idle_rem_q   <= `TMF_RST_IDLE_REMOVE;
        size_limit_q <= `TMF_RST_SIZE_LIMIT;
        irq_msk_q    <= `TMF_RST_IRQ_MASK;
    end
    else if (wr)
    begin
        case (avs_address)
            `TMF_IDX_SCRATCH:
                scratch_q <= (avs_writedata & be_mask)
                           | (scratch_q & ~be_mask);
            `TMF_IDX_FAULT_CTRL:
                if (LINK_FAULT_EN != 0)
                    fault_ctrl_q <= ctrl_wd;
            `TMF_IDX_IDLE_REMOVE:
                if (IDLE_DEFICIT != 0 && avs_byteenable[0])
                    idle_rem_q <= avs_writedata[7:0];
            `TMF_IDX_SIZE_LIMIT:
            begin
                if (avs_byteenable[0])
                    size_limit_q[7:0] <= avs_writedata[7:0];
                if (avs_byteenable[1])
                    size_limit_q[15:8] <= avs_writedata[15:8];
            end
            `TMF_IDX_IRQ_MASK:
                if (avs_byteenable[0])
                    irq_msk_q <= avs_writedata[2:0];
            default:
                scratch_q <= scratch_q;
        endcase
    end
end

// ==========================================================
// Fault flags, oversize counter, interrupt status
always @(posedge ref_clk)
begin
    if (!resetn)
    begin
        flags_q      <= `TMF_RST_FAULT_FLAGS;
        flags_prev_q <= `TMF_RST_FAULT_FLAGS;
        ovs_cnt_q    <= 64'h0000000000000000;
        ovs_evt_q    <= 1'b0;
        irq_sts_q    <= 3'h0;
    end
    else
    begin
        flags_q      <= flags_d;
        flags_prev_q <= flags_q;
        ovs_evt_q    <= 1'b0;
        if (TX_STATS != 0 && tx_frame_done
            && tx_frame_len > size_limit_q)
        begin
            ovs_cnt_q <= ovs_cnt_q + 64'h0000000000000001;
            ovs_evt_q <= 1'b1;
        end
        // New events win over a clear in the same cycle
        if (wr && avs_address == `TMF_IDX_IRQ_STATUS && avs_byteenable[0])
            irq_sts_q <= (irq_sts_q & ~avs_writedata[2:0]) | irq_evt;
        else
            irq_sts_q <= irq_sts_q | irq_evt;
    end
end

// ==========================================================
// Read mux and handshake
reg  [31:0] rd_d;

always @*
begin
    rd_d = `TMF_RD_MISS;
    case (avs_address)
        `TMF_IDX_REVISION:     rd_d = `TMF_REVISION_CODE;
        `TMF_IDX_SCRATCH:      rd_d = scratch_q;
        `TMF_IDX_IDENT_FIRST:  rd_d = `TMF_IDENT_FIRST;
        `TMF_IDX_IDENT_MIDDLE: rd_d = `TMF_IDENT_MIDDLE;
        `TMF_IDX_IDENT_LAST:   rd_d = `TMF_IDENT_LAST;
        `TMF_IDX_FAULT_CTRL:
            if (LINK_FAULT_EN != 0)
                rd_d = {30'h00000000, fault_ctrl_q};
        `TMF_IDX_IDLE_REMOVE:
            if (IDLE_DEFICIT != 0)
                rd_d = {24'h000000, idle_rem_q};
        `TMF_IDX_SIZE_LIMIT:   rd_d = {16'h0000, size_limit_q};
        `TMF_IDX_FAULT_FLAGS:
            if (LINK_FAULT_EN != 0)
                rd_d = {30'h00000000, flags_q};
        `TMF_IDX_IRQ_STATUS:   rd_d = {29'h00000000, irq_sts_q};
        `TMF_IDX_IRQ_MASK:     rd_d = {29'h00000000, irq_msk_q};
        `TMF_IDX_OVS_LOW:
            if (TX_STATS != 0)
                rd_d = ovs_cnt_q[31:0];
        `TMF_IDX_OVS_HIGH:
            if (TX_STATS != 0)
                rd_d = ovs_cnt_q[63:32];
        default:               rd_d = `TMF_RD_MISS;
    endcase
end

// One wait cycle: request seen, answered on the next edge
always @(posedge ref_clk)
begin
    if (!resetn)
    begin
        bus_done_q      <= 1'b0;
        avs_waitrequest <= 1'b1;
        avs_readdata    <= 32'h00000000;
    end
    else
    begin
        bus_done_q      <= acc;
        avs_waitrequest <= !acc;
        if (acc && avs_read)
            avs_readdata <= rd_d;
    end
end

// ==========================================================
// Outputs
always @(posedge ref_clk)
begin
    if (!resetn)
    begin
        local_fault_status        <= 1'b1;
        remote_fault_status       <= 1'b0;
        fault_gen_enable          <= 1'b1;
        unidir_enable             <= 1'b0;
        idle_column_removal_count <= `TMF_RST_IDLE_REMOVE;
        tx_frame_size_limit       <= `TMF_RST_SIZE_LIMIT;
        irq                       <= 1'b0;
    end
    else
    begin
        // Live levels, not gated by the enable bits
        local_fault_status  <= flags_d[`TMF_BIT_LOCAL];
        remote_fault_status <= flags_d[`TMF_BIT_REMOTE];
        // Without the fault option the sequence generator is off once out of reset; reset drives it on
        fault_gen_enable <= (LINK_FAULT_EN != 0)
                          && fault_ctrl_q[`TMF_BIT_FAULT_GEN];
        unidir_enable    <= (LINK_FAULT_EN != 0)
                          && fault_ctrl_q[`TMF_BIT_UNIDIR];
        idle_column_removal_count <= idle_rem_q;
        tx_frame_size_limit       <= size_limit_q;
        irq <= |(irq_sts_q & irq_msk_q);
    end
end

endmodule

// ==== testbench/tmf_mac_regs_assertions.sv ====
// Port-level checks for the transmit MAC register bank
`timescale 1ns/1ps
module tmf_mac_regs_assertions
(
    input wire       ref_clk,
    input wire       resetn,
    input wire       avs_read,
    input wire       avs_write,
    input wire       avs_waitrequest,
    input wire       rx_local_fault,
    input wire       rx_remote_fault,
    input wire       local_fault_status,
    input wire       remote_fault_status,
    input wire       fault_gen_enable,
    input wire       unidir_enable,
    input wire [7:0] idle_column_removal_count
);
// ==========================================
// Bus handshake
default clocking cb @(posedge ref_clk); endclocking
default disable iff (!resetn);
chk_wait_pulse:
    assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low too long");
chk_wait_cause:
    assert property (!avs_waitrequest |-> $past(avs_read || avs_write))
    else $error("answer without request");
chk_wait_answer:
    assert property ((avs_read || avs_write) && avs_waitrequest &&
        $past(avs_waitrequest) |=> !avs_waitrequest)
    else $error("request not answered");
// ==========================================
// Fault levels, three edges of sync latency
chk_local_set:
    assert property (rx_local_fault [*4] |-> local_fault_status)
    else $error("local fault not shown");
chk_local_clear:
    assert property (!rx_local_fault [*4] |-> !local_fault_status)
    else $error("local fault stuck");
chk_remote_set:
    assert property (rx_remote_fault [*4] |-> remote_fault_status)
    else $error("remote fault not shown");
// ==========================================
// Control outputs move only after a write
chk_unidir_cause:
    assert property ($changed(unidir_enable) |->
        $past(avs_write) || $past(avs_write, 2))
    else $error("unidir changed without write");
chk_gen_cause:
    assert property ($changed(fault_gen_enable) |->
        $past(avs_write) || $past(avs_write, 2))
    else $error("fault gen changed without write");
chk_idle_cause:
    assert property ($changed(idle_column_removal_count) |->
        $past(avs_write) || $past(avs_write, 2))
    else $error("idle count changed without write");
endmodule
bind tmf_mac_regs tmf_mac_regs_assertions chk (
    .ref_clk, .resetn, .avs_read, .avs_write, .avs_waitrequest,
    .rx_local_fault, .rx_remote_fault, .local_fault_status,
    .remote_fault_status, .fault_gen_enable, .unidir_enable,
    .idle_column_removal_count
);

// ==== testbench/test_tx_mac_config_fault_regs.sv ====
// Self-checking bench for the transmit MAC register bank
`timescale 1ns/1ps
`include "tmf_regs.vh"
module test_tx_mac_config_fault_regs;
// ==========================================
// Signals and unit under test
reg         ref_clk = 1'b0;
reg         resetn = 1'b0;
reg  [11:0] avs_address = 12'h000;
reg         avs_read = 1'b0;
reg         avs_write = 1'b0;
reg  [31:0] avs_writedata = 32'h00000000;
reg         rx_local_fault = 1'b1;
reg         rx_remote_fault = 1'b0;
reg         tx_frame_done = 1'b0;
reg  [15:0] tx_frame_len = 16'h0000;
reg  [31:0] rd_q;
wire [31:0] avs_readdata;
wire        avs_waitrequest, local_fault_status, remote_fault_status;
wire        fault_gen_enable, unidir_enable, irq;
wire [7:0]  idle_column_removal_count;
wire [15:0] tx_frame_size_limit;
integer     err_total = 0;
integer     comparisons = 0;
tmf_mac_regs uut (
    .ref_clk, .resetn, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable(4'hF), .avs_readdata,
    .avs_waitrequest, .rx_local_fault, .rx_remote_fault, .tx_frame_done,
    .tx_frame_len, .local_fault_status, .remote_fault_status,
    .fault_gen_enable, .unidir_enable, .idle_column_removal_count,
    .tx_frame_size_limit, .irq
);
initial
begin
    forever #5 ref_clk = ~ref_clk;
end
// ==========================================
// Shared tasks
task check(input string what, input [31:0] seen, input [31:0] exp);
begin
    comparisons = comparisons + 1;
    if (seen !== exp)
    begin
        err_total = err_total + 1;
        $display("[ERR] %0s expected %h seen %h", what, exp, seen);
    end
end
endtask
// Request held until waitrequest is sampled low
task bus(input [11:0] a, input w, input [31:0] d);
begin
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    @(posedge ref_clk);
    while (avs_waitrequest !== 1'b0)
        @(posedge ref_clk);
    rd_q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge ref_clk);
end
endtask
task rdc(input [11:0] a, input [31:0] e);
begin
    bus(a, 1'b0, 32'h00000000);
    check("register read", rd_q, e);
end
endtask
task outs(input [31:0] e);
begin
    check("control outputs", {unidir_enable, fault_gen_enable,
        remote_fault_status, local_fault_status}, e);
end
endtask
// ==========================================
// Scenarios
task t_reset;
begin
    rdc(`TMF_IDX_REVISION, `TMF_REVISION_CODE);
    rdc(`TMF_IDX_SCRATCH, 32'h00000000);
    rdc(`TMF_IDX_IDENT_FIRST, `TMF_IDENT_FIRST);
    rdc(`TMF_IDX_IDENT_MIDDLE, `TMF_IDENT_MIDDLE);
    rdc(`TMF_IDX_IDENT_LAST, `TMF_IDENT_LAST);
    rdc(`TMF_IDX_FAULT_CTRL, 32'h00000001);
    rdc(`TMF_IDX_IDLE_REMOVE, 32'h00000014);
    rdc(`TMF_IDX_SIZE_LIMIT, 32'h00002580);
    rdc(`TMF_IDX_FAULT_FLAGS, 32'h00000001);
    outs(32'h5);
    $display("reset values done");
end
endtask
task t_write;
begin
    bus(`TMF_IDX_SCRATCH, 1'b1, 32'hA5C30F96);
    rdc(`TMF_IDX_SCRATCH, 32'hA5C30F96);
    bus(`TMF_IDX_IDENT_FIRST, 1'b1, 32'hFFFFFFFF);
    rdc(`TMF_IDX_IDENT_FIRST, `TMF_IDENT_FIRST);
    bus(`TMF_IDX_FAULT_FLAGS, 1'b1, 32'h00000002);
    rdc(`TMF_IDX_FAULT_FLAGS, 32'h00000001);
    rdc(12'h7FF, 32'h00000000);
    bus(`TMF_IDX_FAULT_CTRL, 1'b1, 32'h00000002);
    rdc(`TMF_IDX_FAULT_CTRL, 32'h00000002);
    outs(32'h9);
    bus(`TMF_IDX_IDLE_REMOVE, 1'b1, 32'h00000030);
    @(posedge ref_clk);
    check("idle count", {24'h0, idle_column_removal_count}, 32'h30);
    bus(`TMF_IDX_SIZE_LIMIT, 1'b1, 32'h00000100);
    @(posedge ref_clk);
    check("size limit", {16'h0, tx_frame_size_limit}, 32'h100);
    $display("register writes done");
end
endtask
task t_fault;
begin
    rx_local_fault <= 1'b0;
    rx_remote_fault <= 1'b1;
    repeat (5) @(posedge ref_clk);
    outs(32'hA);
    rdc(`TMF_IDX_FAULT_FLAGS, 32'h00000002);
    tx_frame_len <= 16'h0101;
    tx_frame_done <= 1'b1;
    @(posedge ref_clk);
    tx_frame_len <= 16'h0100;
    @(posedge ref_clk);
    tx_frame_done <= 1'b0;
    rdc(`TMF_IDX_OVS_LOW, 32'h00000001);
    rdc(`TMF_IDX_OVS_HIGH, 32'h00000000);
    check("irq masked", {31'h0, irq}, 32'h0);
    bus(`TMF_IDX_IRQ_MASK, 1'b1, 32'h00000004);
    repeat (2) @(posedge ref_clk);
    check("irq raised", {31'h0, irq}, 32'h1);
    rdc(`TMF_IDX_IRQ_STATUS, 32'h00000007);
    bus(`TMF_IDX_IRQ_STATUS, 1'b1, 32'h00000007);
    repeat (2) @(posedge ref_clk);
    check("irq cleared", {31'h0, irq}, 32'h0);
    $display("faults and events done");
end
endtask
// ==========================================
// Sequence, watchdog and verdict
task wrap_up;
begin
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
        $display("Testbench passed");
    else
        $display("Testbench failed");
    $finish;
end
endtask
initial
begin
    #20000;
    err_total = err_total + 1;
    wrap_up;
end
initial
begin
    repeat (3) @(posedge ref_clk);
    resetn <= 1'b1;
    t_reset;
    t_write;
    t_fault;
    wrap_up;
end
endmodule
